// ===== rtl/pcdr_top.sv
// pcdr_top: configuration and data registers of four general purpose ports.
// assumes the host bus, logic array terms and address latch all run on mclk;
// pin levels are asynchronous and are synchronised here.
//
// Summary of operation
// (RQ1) ports A/B mode bit 0 gives plain I/O, 1 gives latched address output
// (RQ2) only ports A and B have mode select; C and D stay plain I/O
// (RQ3) direction 1 is output, 0 is input; all inputs after reset
// (RQ4) ports A-C drive when direction or array enable is 1
// (RQ5) port D direction holds only its three low bits
// (RQ6) mode, direction and drive select reset to zero
// (RQ7) drive select 1 on an open-drain pin gives open drain, else push-pull
// (RQ8) drive select 1 on a slew pin gives fast edges, else slow
// (RQ9) A/B: bits 7-4 open drain, 3-0 slew; C all open drain; D 2-0 slew
// (RQ10) bit n of any register acts on pin n only
// (RQ11) registers sit at fixed offsets from io_block_base, plain read/write
// (RQ12) input sample read returns current pin levels
// (RQ13) output latch drives the pin when direction is 1, or array enable on ports A-C only
// (RQ14) output latch reads back the last written value
// (RQ15) cell output read returns cells; write loads cells not blocked
// (RQ16) load block bit 1 stops bus loading of that cell; resets to 0
// (RQ17) input logic cells of ports A, B and C are readable
// (RQ18) ports A-C driver view reads 1 where the driver is enabled, including released open-drain pins; port D reads 0
// (RQ19) port C pins may be lent to the serial test port
// (RQ20) writes to read-only registers have no effect
`timescale 1ns/1ns
`default_nettype none
module pcdr_top
   import pcdr_pkg::*;
#(
   parameter int PORT_D_PINS = PORT_D_PINS_DEF
) (
   input wire logic mclk, // system clock, 250 MHz
   input wire logic srst, // synchronous reset, active high
   input wire logic ce, // clock enable, freezes all state when low
   input wire pcdr_bus_req_s bus_req, // host bus request
   output pcdr_bus_rsp_s bus_rsp, // host read answer
   input wire logic [NUM_PORTS-1:0][7:0] pin_in, // pin levels, asynchronous
   input wire logic [NUM_PORTS-1:0][7:0] arr_oe, // logic array enable terms
   input wire logic [7:0] addr_lat_a, // latched address byte for port A
   input wire logic [7:0] addr_lat_b, // latched address byte for port B
   input wire logic [NUM_CELL_PORTS-1:0][7:0] cell_arr_load, // array loads cell
   input wire logic [NUM_CELL_PORTS-1:0][7:0] cell_arr_next, // array cell value
   input wire logic [NUM_CELL_PORTS-1:0][7:0] in_cell_value, // input cell outputs
   input wire logic [7:0] test_port_sel, // port C pins lent to test port
   output logic [NUM_PORTS-1:0][7:0] pin_out, // pin data
   output logic [NUM_PORTS-1:0][7:0] pin_oe, // pin driven
   output logic [NUM_PORTS-1:0][7:0] pin_fast, // fast slew select
   output logic [NUM_CELL_PORTS-1:0][7:0] cell_out // output cell flip-flops
);

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (PORT_D_PINS < 1 || PORT_D_PINS > PORT_W) begin : g_bad_pins
      $error("pcdr_top: PORT_D_PINS must be 1 to 8");
   end

   localparam logic [7:0] PORT_D_MASK = 8'((16'h1 << PORT_D_PINS) - 16'h1);

   // implemented bits of a port's registers
   function automatic logic [7:0] impl_mask(input int p);
      impl_mask = (p == PORT_D) ? PORT_D_MASK : ALL_PINS;
   endfunction

   // ports that carry a given per-port register
   function automatic logic has_mode(input int p);
      has_mode = (p == PORT_A) || (p == PORT_B);
   endfunction

   function automatic logic has_cells(input int p);
      has_cells = (p < NUM_CELL_PORTS);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] mode_reg [NUM_PORTS];
   logic [7:0] dir_reg [NUM_PORTS];
   logic [7:0] drive_reg [NUM_PORTS];
   logic [7:0] dout_reg [NUM_PORTS];
   logic [7:0] cell_reg [NUM_CELL_PORTS];
   logic [7:0] block_reg [NUM_CELL_PORTS];
   logic [7:0] sync1_reg [NUM_PORTS];
   logic [7:0] sync2_reg [NUM_PORTS];
   logic [7:0] drv_en [NUM_PORTS];
   pcdr_bus_rsp_s rsp_reg;
   pcdr_bus_rsp_s rsp_next;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [PSEL_W-1:0] a_port;
   logic [KIND_W-1:0] a_kind;
   logic a_hit;
   logic wr_go;
   logic rd_go;

   always_comb begin
      a_port = bus_req.addr[PSEL_LSB +: PSEL_W];
      a_kind = bus_req.addr[KIND_LSB +: KIND_W];
      // fixed offsets, upper address bits must be zero (see RQ11)
      a_hit = bus_req.sel && (bus_req.addr[ADDR_W-1 -: 2] == ADDR_HI_ZERO);
      wr_go = a_hit && bus_req.wr;
      rd_go = a_hit && bus_req.rd;
   end

   function automatic logic wr_to(input int p, input logic [3:0] kind);
      wr_to = wr_go && (a_port == PSEL_W'(p)) && (a_kind == kind);
   endfunction

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            mode_reg[p] <= RST_MODE; // see RQ6
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            // ports C and D have no mode select; it stays zero (see RQ2)
            if (has_mode(p) && wr_to(p, OFS_MODE_SELECT)) begin
               mode_reg[p] <= bus_req.wdata;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dir_reg[p] <= RST_DIR; // see RQ3 see RQ6
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_to(p, OFS_DIRECTION)) begin
               dir_reg[p] <= bus_req.wdata & impl_mask(p); // see RQ5
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            drive_reg[p] <= RST_DRIVE; // see RQ6
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_to(p, OFS_DRIVE_SELECT)) begin
               drive_reg[p] <= bus_req.wdata & impl_mask(p); // see RQ9
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // output latch
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dout_reg[p] <= RST_DOUT;
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_to(p, OFS_OUTPUT_LATCH)) begin
               dout_reg[p] <= bus_req.wdata & impl_mask(p); // see RQ13
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // output logic cells and load block
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_CELL_PORTS; p++) begin
            block_reg[p] <= RST_BLOCK; // see RQ16
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_CELL_PORTS; p++) begin
            if (wr_to(p, OFS_CELL_BLOCK)) begin
               block_reg[p] <= bus_req.wdata;
            end
         end
      end
   end

   // a host load and an array load in one cycle: the host value wins on
   // unblocked bits, since software expects to read back what it wrote
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_CELL_PORTS; p++) begin
            cell_reg[p] <= RST_CELL;
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_CELL_PORTS; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
               if (wr_to(p, OFS_CELL_OUTPUT) && !block_reg[p][b]) begin
                  cell_reg[p][b] <= bus_req.wdata[b]; // see RQ15 see RQ16
               end else if (cell_arr_load[p][b]) begin
                  cell_reg[p][b] <= cell_arr_next[p][b];
               end
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < NUM_CELL_PORTS; p++) begin
         cell_out[p] = cell_reg[p];
      end
   end

   // ----------------------------------------------------------------
   // pin input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            sync1_reg[p] <= READ_ZERO;
            sync2_reg[p] <= READ_ZERO;
         end
      end else if (ce) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            sync1_reg[p] <= pin_in[p];
            sync2_reg[p] <= sync1_reg[p];
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      localparam logic [7:0] OD_CAP = (gp == PORT_C) ? OD_CAP_C :
                                      (gp == PORT_D) ? OD_CAP_D : OD_CAP_AB;
      localparam logic [7:0] SLEW_CAP = (gp == PORT_C) ? SLEW_CAP_C :
                                        (gp == PORT_D) ? SLEW_CAP_D : SLEW_CAP_AB;
      logic [7:0] alt_data;
      logic [7:0] oe_term;
      logic [7:0] lent;

      // port D direction is the register alone; test port borrows port C
      assign alt_data = (gp == PORT_A) ? addr_lat_a : addr_lat_b; // see RQ1
      assign oe_term = (gp == PORT_D) ? READ_ZERO : arr_oe[gp]; // see RQ4
      assign lent = (gp == PORT_C) ? test_port_sel : READ_ZERO; // see RQ19

      pcdr_pin_slice #(
         .OD_CAP(OD_CAP),
         .SLEW_CAP(SLEW_CAP),
         .PIN_MASK(impl_mask(gp))
      ) u_slice (
         .mclk(mclk),
         .srst(srst),
         .ce(ce),
         .dout(dout_reg[gp]),
         .alt_sel(mode_reg[gp]),
         .alt_data(alt_data),
         .dir(dir_reg[gp]),
         .arr_oe(oe_term),
         .drive(drive_reg[gp]),
         .release_pins(lent),
         .pin_out(pin_out[gp]),
         .pin_oe(pin_oe[gp]),
         .pin_fast(pin_fast[gp]),
         .drv_en(drv_en[gp])
      );
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // unmapped or missing registers read zero; writes to read-only
   // locations decode to nothing (see RQ20)
   always_comb begin
      rsp_next.valid = rd_go;
      rsp_next.data = READ_ZERO;
      if (rd_go) begin
         case (a_kind)
            OFS_INPUT_SAMPLE: begin
               rsp_next.data = sync2_reg[a_port] & impl_mask(a_port); // see RQ12
            end
            OFS_MODE_SELECT: begin
               rsp_next.data = mode_reg[a_port];
            end
            OFS_OUTPUT_LATCH: begin
               rsp_next.data = dout_reg[a_port]; // see RQ14
            end
            OFS_DIRECTION: begin
               rsp_next.data = dir_reg[a_port];
            end
            OFS_DRIVE_SELECT: begin
               rsp_next.data = drive_reg[a_port];
            end
            OFS_DRIVER_VIEW: begin
               if (has_cells(a_port)) begin
                  rsp_next.data = drv_en[a_port]; // see RQ18
               end
            end
            OFS_CELL_OUTPUT: begin
               if (has_cells(a_port)) begin
                  rsp_next.data = cell_reg[a_port]; // see RQ15
               end
            end
            OFS_CELL_BLOCK: begin
               if (has_cells(a_port)) begin
                  rsp_next.data = block_reg[a_port];
               end
            end
            OFS_CELL_INPUT: begin
               if (has_cells(a_port)) begin
                  rsp_next.data = in_cell_value[a_port]; // see RQ17
               end
            end
            default: begin
               rsp_next.data = READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rsp_reg <= '0;
      end else if (ce) begin
         rsp_reg <= rsp_next;
      end
   end

   assign bus_rsp = rsp_reg;

endmodule
`default_nettype wire

// ===== rtl/pcdr_pkg.sv
// pcdr_pkg: register map, field layouts and bus carrier for the port setup registers.
// assumes one mclk domain; the host bus request arrives already on mclk.
package pcdr_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int NUM_PORTS = 4;
   localparam int NUM_CELL_PORTS = 3;
   localparam int PORT_W = 8;
   localparam int PORT_A = 0;
   localparam int PORT_B = 1;
   localparam int PORT_C = 2;
   localparam int PORT_D = 3;
   localparam int PORT_D_PINS_DEF = 3;

   // ----------------------------------------------------------------
   // address map: byte offset from io_block_base = {port, kind}
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int KIND_LSB = 0;
   localparam int KIND_W = 4;
   localparam int PSEL_LSB = 4;
   localparam int PSEL_W = 2;
   localparam logic [3:0] OFS_INPUT_SAMPLE = 4'h0;
   localparam logic [3:0] OFS_MODE_SELECT = 4'h1;
   localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h2;
   localparam logic [3:0] OFS_DIRECTION = 4'h3;
   localparam logic [3:0] OFS_DRIVE_SELECT = 4'h4;
   localparam logic [3:0] OFS_DRIVER_VIEW = 4'h5;
   localparam logic [3:0] OFS_CELL_OUTPUT = 4'h6;
   localparam logic [3:0] OFS_CELL_BLOCK = 4'h7;
   localparam logic [3:0] OFS_CELL_INPUT = 4'h8;
   localparam logic [1:0] ADDR_HI_ZERO = 2'h0;

   // ----------------------------------------------------------------
   // reset values and drive select capability per port
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_DRIVE = 8'h00;
   localparam logic [7:0] RST_DOUT = 8'h00;
   localparam logic [7:0] RST_CELL = 8'h00;
   localparam logic [7:0] RST_BLOCK = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam logic [7:0] ALL_PINS = 8'hff;
   localparam logic [7:0] OD_CAP_AB = 8'hf0;
   localparam logic [7:0] SLEW_CAP_AB = 8'h0f;
   localparam logic [7:0] OD_CAP_C = 8'hff;
   localparam logic [7:0] SLEW_CAP_C = 8'h00;
   localparam logic [7:0] OD_CAP_D = 8'h00;
   localparam logic [7:0] SLEW_CAP_D = 8'hff;

   // ----------------------------------------------------------------
   // bus carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [PORT_W-1:0] wdata;
   } pcdr_bus_req_s;

   typedef struct packed {
      logic valid;
      logic [PORT_W-1:0] data;
   } pcdr_bus_rsp_s;

endpackage

// ===== rtl/pcdr_pin_slice.sv
// pcdr_pin_slice: output stage of one port, registered pin data, enable and slew.
// assumes configuration inputs are on mclk; the pad ring resolves the pin level.
`timescale 1ns/1ns
`default_nettype none
module pcdr_pin_slice
   import pcdr_pkg::*;
#(
   parameter logic [7:0] OD_CAP = 8'h00,
   parameter logic [7:0] SLEW_CAP = 8'h00,
   parameter logic [7:0] PIN_MASK = 8'hff
) (
   input wire logic mclk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic ce, // clock enable
   input wire logic [7:0] dout, // output latch value
   input wire logic [7:0] alt_sel, // pin carries latched address
   input wire logic [7:0] alt_data, // latched address byte
   input wire logic [7:0] dir, // direction bits
   input wire logic [7:0] arr_oe, // logic array enable terms
   input wire logic [7:0] drive, // drive select bits
   input wire logic [7:0] release_pins, // pins lent to the test port
   output logic [7:0] pin_out, // pin data
   output logic [7:0] pin_oe, // pin driven
   output logic [7:0] pin_fast, // fast edge select
   output logic [7:0] drv_en // driver enabled view
);

   logic [7:0] en_next;
   logic [7:0] data_next;
   logic [7:0] od_sel;

   // ----------------------------------------------------------------
   // per pin driver decision
   // ----------------------------------------------------------------
   always_comb begin
      // each bit drives only its own pin (see RQ10)
      en_next = (dir | arr_oe) & ~release_pins & PIN_MASK; // see RQ4 see RQ13
      data_next = (alt_sel & alt_data) | (~alt_sel & dout); // see RQ1
      od_sel = drive & OD_CAP; // see RQ7
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_out <= RST_DOUT;
         pin_oe <= RST_DIR;
         pin_fast <= RST_DRIVE;
         drv_en <= RST_DIR;
      end else if (ce) begin
         // open drain only sinks: a high level releases the pin
         pin_out <= data_next & ~od_sel;
         pin_oe <= en_next & ~(od_sel & data_next);
         pin_fast <= drive & SLEW_CAP & PIN_MASK; // see RQ8
         drv_en <= en_next; // see RQ18
      end
   end

endmodule
`default_nettype wire

// ===== tb/pcdr_top_sva.sv
// pcdr_top_sva: port-level checks of the port setup registers.
// assumes a single mclk domain; bound onto every pcdr_top instance.
`timescale 1ns/1ns
`default_nettype none
module pcdr_top_sva
   import pcdr_pkg::*;
#(
   parameter int PORT_D_PINS = PORT_D_PINS_DEF
) (
   input wire logic mclk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic ce, // clock enable
   input wire pcdr_bus_req_s bus_req, // host request
   input wire pcdr_bus_rsp_s bus_rsp, // host answer
   input wire logic [NUM_PORTS-1:0][7:0] arr_oe, // array enable terms
   input wire logic [7:0] test_port_sel, // port C pins lent out
   input wire logic [NUM_PORTS-1:0][7:0] pin_oe, // pin driven
   input wire logic [NUM_PORTS-1:0][7:0] pin_fast // fast slew
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic rd_take;
   logic d_sel;
   assign rd_take = ce && bus_req.sel && bus_req.rd && bus_req.addr[7:6] == ADDR_HI_ZERO;
   assign d_sel = bus_req.addr[5:4] == 2'h3;
   // ------------
   // bus
   // ------------
   property p_rd_answer;
      rd_take |=> bus_rsp.valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_no_stray;
      ce && !(bus_req.sel && bus_req.rd) |=> !bus_rsp.valid;
   endproperty
   a_no_stray: assert property (p_no_stray) else $error("answer without read");
   property p_unknown_kind;
      rd_take && bus_req.addr[3:0] > OFS_CELL_INPUT |=> bus_rsp.data == READ_ZERO;
   endproperty
   a_unknown_kind: assert property (p_unknown_kind) else $error("unmapped read not 0");
   property p_d_view;
      rd_take && d_sel && bus_req.addr[3:0] == OFS_DRIVER_VIEW |=> bus_rsp.data == READ_ZERO;
   endproperty
   a_d_view: assert property (p_d_view) else $error("port D driver view not 0");
   property p_d_upper;
      rd_take && d_sel && bus_req.addr[3:0] <= OFS_DRIVE_SELECT
         |=> (bus_rsp.data >> PORT_D_PINS) == 8'h00;
   endproperty
   a_d_upper: assert property (p_d_upper) else $error("port D upper bits set");
   // ------------
   // pins
   // ------------
   property p_d_oe;
      (pin_oe[PORT_D] >> PORT_D_PINS) == 8'h00;
   endproperty
   a_d_oe: assert property (p_d_oe) else $error("missing port D pin driven");
   property p_lent_c;
      ce |=> (pin_oe[PORT_C] & $past(test_port_sel)) == 8'h00;
   endproperty
   a_lent_c: assert property (p_lent_c) else $error("lent port C pin driven");
   // low nibbles of A and B have no open drain, so an enable term must drive
   property p_oe_or;
      ce |=> ({$past(arr_oe[1][3:0]), $past(arr_oe[0][3:0])}
         & ~{pin_oe[1][3:0], pin_oe[0][3:0]}) == 8'h00;
   endproperty
   a_oe_or: assert property (p_oe_or) else $error("enable term not driving");
   property p_fast_cap;
      (pin_fast[0] & ~SLEW_CAP_AB) == 8'h00 && (pin_fast[1] & ~SLEW_CAP_AB) == 8'h00
         && pin_fast[2] == 8'h00 && (pin_fast[3] >> PORT_D_PINS) == 8'h00;
   endproperty
   a_fast_cap: assert property (p_fast_cap) else $error("fast edge without slew");
   c_read: cover property (rd_take ##1 bus_rsp.valid);
   c_lent: cover property (ce && test_port_sel != 8'h00);
   c_oe: cover property (pin_oe[0] != 8'h00);
endmodule
bind pcdr_top pcdr_top_sva #(.PORT_D_PINS(PORT_D_PINS)) pcdr_top_sva_i (
   .mclk(mclk), .srst(srst), .ce(ce), .bus_req(bus_req), .bus_rsp(bus_rsp),
   .arr_oe(arr_oe), .test_port_sel(test_port_sel), .pin_oe(pin_oe), .pin_fast(pin_fast));
`default_nettype wire

// ===== tb/pcdr_pad_model.sv
// pcdr_pad_model: board side of the port pins, resolving each wire level.
// assumes pull-ups on every pin; the device wins where both would drive.
`timescale 1ns/1ns
`default_nettype none
module pcdr_pad_model
   import pcdr_pkg::*;
(
   input wire logic [NUM_PORTS-1:0][7:0] pin_out, // device pin data
   input wire logic [NUM_PORTS-1:0][7:0] pin_oe, // device drives
   input wire logic [NUM_PORTS-1:0][7:0] ext_val, // board drive value
   input wire logic [NUM_PORTS-1:0][7:0] ext_en, // board drives
   output logic [NUM_PORTS-1:0][7:0] pin_lvl // wire level
);
   // released open-drain pins float high, never the last driven value
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & (~ext_en | ext_val));
endmodule
`default_nettype wire

// ===== tb/port_config_data_registers_tb.sv
// port_config_data_registers_tb: self-checking bench of pcdr_top.
// assumes pcdr_pkg, pcdr_top and pcdr_pad_model compiled before it.
`timescale 1ns/1ns
`default_nettype none
module port_config_data_registers_tb;
   import pcdr_pkg::*;
   localparam logic [7:0] DMASK = 8'hff >> (8 - PORT_D_PINS_DEF);
   logic mclk, srst, ce;
   pcdr_bus_req_s bus_req;
   pcdr_bus_rsp_s bus_rsp;
   logic [3:0][7:0] pin_in, arr_oe, pin_out, pin_oe, pin_fast, ext_val, ext_en;
   logic [3:0][7:0] m_mode, m_dir, m_drv, m_lat, m_cell, m_blk;
   logic [7:0] addr_lat_a, addr_lat_b, test_port_sel;
   logic [2:0][7:0] cell_arr_load, cell_arr_next, in_cell_value, cell_out;
   logic [7:0] expq[$];
   int fails, compares, seed;
   pcdr_top #(.PORT_D_PINS(PORT_D_PINS_DEF)) pcdr_top_i (.mclk(mclk), .srst(srst), .ce(ce),
      .bus_req(bus_req), .bus_rsp(bus_rsp), .pin_in(pin_in), .arr_oe(arr_oe),
      .addr_lat_a(addr_lat_a), .addr_lat_b(addr_lat_b), .cell_arr_load(cell_arr_load),
      .cell_arr_next(cell_arr_next), .in_cell_value(in_cell_value),
      .test_port_sel(test_port_sel), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_fast(pin_fast), .cell_out(cell_out));
   pcdr_pad_model pcdr_pad_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(pin_in));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // ------------
   // expected pin behaviour
   // ------------
   function automatic logic [7:0] en(input int p);
      if (p == 3) return m_dir[3];
      return (m_dir[p] | arr_oe[p]) & ~(p == 2 ? test_port_sel : 8'h00);
   endfunction
   function automatic logic [7:0] dat(input int p);
      if (p > 1) return m_lat[p];
      return ((p == 0 ? addr_lat_a : addr_lat_b) & m_mode[p]) | (m_lat[p] & ~m_mode[p]);
   endfunction
   function automatic logic [7:0] odb(input int p);
      return p < 2 ? m_drv[p] & OD_CAP_AB : (p == 2 ? m_drv[p] : 8'h00);
   endfunction
   function automatic logic [7:0] oex(input int p);
      return en(p) & ~(odb(p) & dat(p));
   endfunction
   function automatic logic [7:0] rexp(input int p, input logic [3:0] k);
      case (k)
         OFS_INPUT_SAMPLE: return ((oex(p) & dat(p) & ~odb(p))
            | (~oex(p) & (~ext_en[p] | ext_val[p]))) & (p == 3 ? DMASK : ALL_PINS);
         OFS_MODE_SELECT: return m_mode[p];
         OFS_OUTPUT_LATCH: return m_lat[p];
         OFS_DIRECTION: return m_dir[p];
         OFS_DRIVE_SELECT: return m_drv[p];
         OFS_DRIVER_VIEW: return p == 3 ? READ_ZERO : en(p);
         OFS_CELL_OUTPUT: return m_cell[p];
         OFS_CELL_BLOCK: return m_blk[p];
         OFS_CELL_INPUT: return p == 3 ? READ_ZERO : in_cell_value[p];
         default: return READ_ZERO;
      endcase
   endfunction
   // ------------
   // bus and checks
   // ------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      bus_req = '{sel: 1'b1, wr: w, rd: r, addr: a, wdata: d};
      @(posedge mclk);
      #1;
   endtask
   task automatic idle(input int n);
      bus_req = '0;
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic rd(input int p, input logic [3:0] k);
      expq.push_back(rexp(p, k));
      bus(1'b0, 1'b1, {2'h0, 2'(p), k}, 8'h00);
   endtask
   task automatic wr(input int p, input logic [3:0] k, input logic [7:0] d);
      logic [7:0] m;
      m = p == 3 ? DMASK : ALL_PINS;
      case (k)
         OFS_MODE_SELECT: if (p < 2) m_mode[p] = d;
         OFS_OUTPUT_LATCH: m_lat[p] = d & m;
         OFS_DIRECTION: m_dir[p] = d & m;
         OFS_DRIVE_SELECT: m_drv[p] = d & m;
         OFS_CELL_OUTPUT: if (p < 3) m_cell[p] = (d & ~m_blk[p]) | (m_cell[p] & m_blk[p]);
         OFS_CELL_BLOCK: if (p < 3) m_blk[p] = d;
         default: ;
      endcase
      bus(1'b1, 1'b0, {2'h0, 2'(p), k}, d);
   endtask
   task automatic pins();
      for (int p = 0; p < NUM_PORTS; p++) begin
         check("pin_oe", pin_oe[p], oex(p));
         check("pin_out", pin_out[p] & pin_oe[p], dat(p) & ~odb(p) & oex(p));
         check("pin_fast", pin_fast[p], p == 2 ? 8'h00 : m_drv[p] & ~odb(p));
         if (p < 3) check("cell_out", cell_out[p], m_cell[p]);
      end
   endtask
   task automatic reads();
      for (int p = 0; p < NUM_PORTS; p++)
         for (int k = 0; k < 10; k++) rd(p, 4'(k));
      idle(3);
   endtask
   always @(negedge mclk) begin
      if (bus_rsp.valid === 1'b1) begin
         if (expq.size() == 0) check("bus_rsp.valid", 8'h01, 8'h00);
         else check("bus_rsp.data", bus_rsp.data, expq.pop_front());
      end
   end
   task automatic end_sim();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // whole run is well under 2000 cycles; this limit only catches a hang
   initial begin
      #100000;
      fails++;
      end_sim();
   end
   // ------------
   // main sequence
   // ------------
   initial begin
      seed = 32'habd6;
      {ce, srst} = 2'b11;
      bus_req = '0;
      {arr_oe, ext_val, ext_en, m_mode, m_dir, m_drv, m_lat, m_cell, m_blk} = '0;
      {addr_lat_a, addr_lat_b, test_port_sel} = '0;
      {cell_arr_load, cell_arr_next, in_cell_value} = '0;
      repeat (6) @(posedge mclk);
      #1 srst = 1'b0;
      // two edges fill the pin synchroniser first
      idle(2);
      pins();
      reads();
      for (int r = 0; r < 4; r++) begin
         arr_oe = $random(seed);
         ext_val = $random(seed);
         ext_en = $random(seed);
         {addr_lat_a, addr_lat_b, test_port_sel} = 24'($random(seed));
         in_cell_value = 24'($random(seed));
         for (int p = 0; p < NUM_PORTS; p++)
            for (int k = 0; k < 10; k++) wr(p, 4'(k), 8'($random(seed)));
         idle(4);
         pins();
         reads();
      end
      // array loads land beside the bus, block bits do not stop them
      cell_arr_load = 24'($random(seed));
      cell_arr_next = 24'($random(seed));
      for (int p = 0; p < 3; p++)
         m_cell[p] = (cell_arr_load[p] & cell_arr_next[p]) | (~cell_arr_load[p] & m_cell[p]);
      @(posedge mclk);
      #1 cell_arr_load = '0;
      idle(2);
      pins();
      // frozen clock enable: neither the write nor the read is taken
      ce = 1'b0;
      bus(1'b1, 1'b0, 8'h03, ~m_dir[0]);
      bus(1'b0, 1'b1, 8'h03, 8'h00);
      ce = 1'b1;
      idle(2);
      rd(0, OFS_DIRECTION);
      idle(3);
      check("pending reads", 8'(expq.size()), 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
